// ===== logic/boot_config.sv
// Boot-source selection, switch configuration and self-test with an APB register port
//
// The address map and register access over APB were decided locally.
`default_nettype none
module boot_config #(
  parameter int SELFTEST_CYCLES = boot_cfg_pkg::SELFTEST_CYC
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  input  wire logic [boot_cfg_pkg::ROW_W-1:0] sw_row,
  input  wire logic [boot_cfg_pkg::COL_W-1:0] sw_col,
  input  wire logic                          sw_protect,
  input  wire logic                          sw_loader,
  input  wire logic                          sw_aux1,
  input  wire logic                          sw_aux2,
  input  wire logic                          selftest_fault,
  input  wire logic                          nv_flag_in,
  input  wire logic [boot_cfg_pkg::SR_W-1:0]  oper_cond,
  input  wire logic [boot_cfg_pkg::SR_W-1:0]  ques_cond,
  output var  logic [boot_cfg_pkg::LED_N-1:0] led,
  output var  logic                          run_loader,
  output var  logic                          prog_erase,
  output var  logic                          nv_wr_en,
  output var  logic                          nv_wr_data
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  boot_cfg_pkg::state_t state_q;
  boot_cfg_pkg::state_t state_d;

  logic [boot_cfg_pkg::CNT_W-1:0] cnt_q;
  logic [boot_cfg_pkg::CNT_W-1:0] cnt_d;
  logic [31:0]                    prdata_d;
  logic                           pready_d;
  logic                           pslverr_d;
  logic [boot_cfg_pkg::LED_N-1:0] led_d;
  logic                           run_loader_d;
  logic                           prog_erase_d;
  logic [31:0]                    outq_q;
  logic [31:0]                    outq_d;
  logic [15:0]                    err_q;
  logic [15:0]                    err_d;
  logic                           reject_q;
  logic                           reject_d;
  logic [boot_cfg_pkg::SR_W-1:0]  oper_en_q;
  logic [boot_cfg_pkg::SR_W-1:0]  oper_en_d;
  logic [boot_cfg_pkg::SR_W-1:0]  ques_en_q;
  logic [boot_cfg_pkg::SR_W-1:0]  ques_en_d;
  logic                           nv_req;
  logic                           nv_val;
  logic                           nv_load;
  logic                           nv_stored;
  logic                           nv_busy;
  logic                           setup;
  logic                           wr;
  logic                           rd;
  logic                           mapped;
  logic                           addr_illegal;
  logic [3:0]                     cmd;
  logic [boot_cfg_pkg::SR_W-1:0]  oper_evt;
  logic [boot_cfg_pkg::SR_W-1:0]  ques_evt;
  logic [31:0]                    status;
  logic                           test_end;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // One wait state: pready rises in the second access cycle, the
  // write or read-clear lands on that edge.
  assign setup  = psel && penable && !pready;
  assign wr     = psel && penable && pready && pwrite;
  assign rd     = psel && penable && pready && !pwrite;
  assign cmd    = pwdata[boot_cfg_pkg::CMD_W-1:0];
  assign mapped = (paddr == boot_cfg_pkg::OFF_CMD)    || (paddr == boot_cfg_pkg::OFF_STATUS)
               || (paddr == boot_cfg_pkg::OFF_OUTQ)   || (paddr == boot_cfg_pkg::OFF_ERR)
               || (paddr == boot_cfg_pkg::OFF_OPER)   || (paddr == boot_cfg_pkg::OFF_QUES);

  // Address straps; the spare switches are deliberately left unread
  assign addr_illegal = (sw_row == boot_cfg_pkg::ILLEGAL_ROW)
                     && (sw_col == boot_cfg_pkg::ILLEGAL_COL);

  // Loader image never sets an operation or questionable event bit, only the application does
  assign oper_evt = run_loader ? '0 : oper_cond;
  assign ques_evt = run_loader ? '0 : ques_cond;

  always_comb begin
    status                              = '0;
    status[boot_cfg_pkg::ST_ADDR +: 8]  = {sw_row, sw_col};
    status[boot_cfg_pkg::ST_ILLEGAL]    = addr_illegal;
    status[boot_cfg_pkg::ST_PROTECT]    = sw_protect;
    status[boot_cfg_pkg::ST_LDR_SW]     = sw_loader;
    status[boot_cfg_pkg::ST_LDR_RUN]    = run_loader;
    status[boot_cfg_pkg::ST_STORED]     = nv_stored;
    status[boot_cfg_pkg::ST_BUSY]       = (state_q != boot_cfg_pkg::S_READY);
    status[boot_cfg_pkg::ST_NV_BUSY]    = nv_busy;
    status[boot_cfg_pkg::ST_REJECT]     = reject_q;
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup && !mapped;
    prdata_d  = prdata;
    if (setup && !pwrite) begin
      case (paddr)
        boot_cfg_pkg::OFF_STATUS: prdata_d = status;
        boot_cfg_pkg::OFF_OUTQ:   prdata_d = outq_q;
        boot_cfg_pkg::OFF_ERR:    prdata_d = {16'h0000, err_q};
        boot_cfg_pkg::OFF_OPER:   prdata_d = {oper_evt & oper_en_q, oper_en_q};
        boot_cfg_pkg::OFF_QUES:   prdata_d = {ques_evt & ques_en_q, ques_en_q};
        default:                  prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ****************************************************************
  // Sequencer and command handling
  // ****************************************************************
  assign test_end = (cnt_q == '0);

  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    led_d        = led;
    run_loader_d = run_loader;
    prog_erase_d = 1'b0;
    outq_d       = outq_q;
    err_d        = err_q;
    reject_d     = reject_q;
    oper_en_d    = oper_en_q;
    ques_en_d    = ques_en_q;
    nv_req       = 1'b0;
    nv_val       = 1'b0;
    nv_load      = 1'b0;

    // Reads clear; an event on the same edge below still wins
    if (rd && paddr == boot_cfg_pkg::OFF_OUTQ) begin
      outq_d = '0;
    end
    if (rd && paddr == boot_cfg_pkg::OFF_ERR) begin
      err_d = boot_cfg_pkg::ERR_NONE;
    end
    if (rd && paddr == boot_cfg_pkg::OFF_STATUS) begin
      reject_d = 1'b0;
    end
    if (wr && paddr == boot_cfg_pkg::OFF_OPER) begin
      oper_en_d = pwdata[boot_cfg_pkg::SR_W-1:0];
    end
    if (wr && paddr == boot_cfg_pkg::OFF_QUES) begin
      ques_en_d = pwdata[boot_cfg_pkg::SR_W-1:0];
    end

    case (state_q)
      boot_cfg_pkg::S_POWERUP: begin
        // Fetch the stored flag before the image decision
        nv_load = 1'b1;
        led_d   = '1;
        cnt_d   = boot_cfg_pkg::CNT_W'(SELFTEST_CYCLES - 1);
        state_d = boot_cfg_pkg::S_TEST;
      end
      boot_cfg_pkg::S_TEST: begin
        led_d = '1;
        if (test_end) begin
          led_d        = '0;
          run_loader_d = sw_loader || nv_stored;
          if (sw_loader || nv_stored) begin
            nv_req = 1'b1;
            nv_val = 1'b0;
          end
          state_d = boot_cfg_pkg::S_READY;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      boot_cfg_pkg::S_QUERY_TEST: begin
        // Indicators and configuration are left alone on a queried test
        if (test_end) begin
          outq_d                        = '0;
          outq_d[boot_cfg_pkg::OQ_VALID] = 1'b1;
          outq_d[boot_cfg_pkg::OQ_DATA]  = selftest_fault;
          state_d                       = boot_cfg_pkg::S_READY;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      boot_cfg_pkg::S_READY: begin
        if (wr && paddr == boot_cfg_pkg::OFF_CMD) begin
          case (cmd)
            boot_cfg_pkg::CMD_BOOT_INST: begin
              nv_req = 1'b1;
              nv_val = 1'b0;
            end
            boot_cfg_pkg::CMD_BOOT_LOADER: begin
              nv_req = 1'b1;
              nv_val = 1'b1;
            end
            boot_cfg_pkg::CMD_BOOT_QUERY: begin
              outq_d                        = '0;
              outq_d[boot_cfg_pkg::OQ_VALID] = 1'b1;
              outq_d[boot_cfg_pkg::OQ_KIND]  = 1'b1;
              outq_d[boot_cfg_pkg::OQ_DATA]  = nv_stored;
            end
            boot_cfg_pkg::CMD_SELFTEST: begin
              cnt_d   = boot_cfg_pkg::CNT_W'(SELFTEST_CYCLES - 1);
              state_d = boot_cfg_pkg::S_QUERY_TEST;
            end
            boot_cfg_pkg::CMD_ERASE: begin
              if (!run_loader) begin
                reject_d = 1'b1;
              end else if (sw_protect) begin
                err_d = boot_cfg_pkg::ERR_MEDIA_PROTECTED;
              end else begin
                prog_erase_d = 1'b1;
              end
            end
            boot_cfg_pkg::CMD_LOAD_OK: begin
              if (!run_loader) begin
                reject_d = 1'b1;
              end else if (sw_protect) begin
                err_d = boot_cfg_pkg::ERR_PROG_PROTECTED;
              end else begin
                nv_req = 1'b1;
                nv_val = 1'b0;
              end
            end
            boot_cfg_pkg::CMD_RESET: begin
              nv_req = 1'b1;
              nv_val = 1'b0;
            end
            boot_cfg_pkg::CMD_APP: begin
              // Application commands are ignored but flagged in the loader
              if (run_loader) begin
                reject_d = 1'b1;
              end
            end
            default: begin
              reject_d = reject_d;
            end
          endcase
        end
      end
      default: begin
        state_d = boot_cfg_pkg::S_POWERUP;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= boot_cfg_pkg::S_POWERUP;
      cnt_q      <= '0;
      led        <= '0;
      run_loader <= 1'b0;
      prog_erase <= 1'b0;
      outq_q     <= '0;
      err_q      <= boot_cfg_pkg::ERR_NONE;
      reject_q   <= 1'b0;
      oper_en_q  <= '0;
      ques_en_q  <= '0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      led        <= led_d;
      run_loader <= run_loader_d;
      prog_erase <= prog_erase_d;
      outq_q     <= outq_d;
      err_q      <= err_d;
      reject_q   <= reject_d;
      oper_en_q  <= oper_en_d;
      ques_en_q  <= ques_en_d;
    end
  end

  // ****************************************************************
  // Nonvolatile boot-source store
  // ****************************************************************
  nv_boot_store u_store (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (nv_load),
    .flag_in   (nv_flag_in),
    .req       (nv_req),
    .req_val   (nv_val),
    .stored_q  (nv_stored),
    .busy      (nv_busy),
    .wr_en_q   (nv_wr_en),
    .wr_data_q (nv_wr_data)
  );
endmodule // boot_config
`default_nettype wire

// ===== pkg/boot_cfg_pkg.sv
// Constants, register map and types for the boot-source and configuration block
`default_nettype none
package boot_cfg_pkg;
  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_OUTQ   = 8'h08;
  localparam logic [7:0] OFF_ERR    = 8'h0C;
  localparam logic [7:0] OFF_OPER   = 8'h10;
  localparam logic [7:0] OFF_QUES   = 8'h14;

  // Command codes written to the low nibble of the command register
  localparam logic [3:0] CMD_BOOT_INST   = 4'h1;
  localparam logic [3:0] CMD_BOOT_LOADER = 4'h2;
  localparam logic [3:0] CMD_BOOT_QUERY  = 4'h3;
  localparam logic [3:0] CMD_SELFTEST    = 4'h4;
  localparam logic [3:0] CMD_ERASE       = 4'h5;
  localparam logic [3:0] CMD_LOAD_OK     = 4'h6;
  localparam logic [3:0] CMD_RESET       = 4'h7;
  localparam logic [3:0] CMD_APP         = 4'h8;
  localparam int         CMD_W           = 4;

  // Status register fields
  localparam int ST_ADDR    = 0;
  localparam int ST_ILLEGAL = 8;
  localparam int ST_PROTECT = 9;
  localparam int ST_LDR_SW  = 10;
  localparam int ST_LDR_RUN = 11;
  localparam int ST_STORED  = 12;
  localparam int ST_BUSY    = 13;
  localparam int ST_NV_BUSY = 14;
  localparam int ST_REJECT  = 15;

  // Output queue fields: kind 0 self-test (data 1 = fail), kind 1 boot (data 1 = loader)
  localparam int OQ_VALID = 31;
  localparam int OQ_KIND  = 30;
  localparam int OQ_DATA  = 0;

  // Operation/questionable: enable in low half, event in high half
  localparam int SR_W   = 16;
  localparam int SR_EVT = 16;

  // Error codes, 16-bit two's complement
  localparam logic [15:0] ERR_NONE            = 16'h0000;
  localparam logic [15:0] ERR_MEDIA_PROTECTED = 16'hFEFE;
  localparam logic [15:0] ERR_PROG_PROTECTED  = 16'h0DAF;

  // Address switches
  localparam int         ROW_W       = 3;
  localparam int         COL_W       = 5;
  localparam logic [2:0] ILLEGAL_ROW = 3'h0;
  localparam logic [4:0] ILLEGAL_COL = 5'h1F;

  // Front indicators
  localparam int LED_N = 11;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ        = 25;
  localparam int SELFTEST_US    = 1000;
  localparam int SELFTEST_CYC   = SELFTEST_US * CLK_MHZ;
  localparam int NV_WRITE_US    = 10;
  localparam int NV_WRITE_CYC   = NV_WRITE_US * CLK_MHZ;
  localparam int CNT_W          = 16;
  localparam int NV_WRITES_RATED = 10000;

  typedef enum logic [1:0] {S_POWERUP, S_TEST, S_READY, S_QUERY_TEST} state_t;
endpackage
`default_nettype wire

// ===== logic/nv_boot_store.sv
// Stored boot-source flag with write-on-change to nonvolatile memory
`default_nettype none
module nv_boot_store (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic load,
  input  wire logic flag_in,
  input  wire logic req,
  input  wire logic req_val,
  output var  logic stored_q,
  output var  logic busy,
  output var  logic wr_en_q,
  output var  logic wr_data_q
);
  logic                           stored_d;
  logic                           pend_q;
  logic                           pend_d;
  logic                           wr_en_d;
  logic                           wr_data_d;
  logic [boot_cfg_pkg::CNT_W-1:0] cnt_q;
  logic [boot_cfg_pkg::CNT_W-1:0] cnt_d;

  always_comb begin
    stored_d  = stored_q;
    pend_d    = pend_q;
    wr_en_d   = 1'b0;
    wr_data_d = wr_data_q;
    cnt_d     = cnt_q;
    busy      = (cnt_q != '0);
    if (load) begin
      stored_d  = flag_in;
      // Mirror of the cell's content, so an unchanged value is never rewritten
      wr_data_d = flag_in;
    end else if (req && (req_val != stored_q)) begin
      stored_d = req_val;
      pend_d   = 1'b1;
    end
    if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end else if (pend_q) begin
      // Latest value wins; a change made during a write is written after it,
      // unless it has gone back to what the cell already holds
      pend_d = pend_d && (stored_d != stored_q);
      if (stored_q != wr_data_q) begin
        wr_en_d   = 1'b1;
        wr_data_d = stored_q;
        cnt_d     = boot_cfg_pkg::CNT_W'(boot_cfg_pkg::NV_WRITE_CYC);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_q  <= 1'b0;
      pend_q    <= 1'b0;
      wr_en_q   <= 1'b0;
      wr_data_q <= 1'b0;
      cnt_q     <= '0;
    end else begin
      stored_q  <= stored_d;
      pend_q    <= pend_d;
      wr_en_q   <= wr_en_d;
      wr_data_q <= wr_data_d;
      cnt_q     <= cnt_d;
    end
  end
endmodule // nv_boot_store
`default_nettype wire

// ===== testbench/boot_config_properties.sv
// Port-level assertions for the boot-source and configuration block
`default_nettype none
module boot_config_properties #(
  parameter int SELFTEST_CYCLES = boot_cfg_pkg::SELFTEST_CYC
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [2:0]  sw_row,
  input wire logic [4:0]  sw_col,
  input wire logic        sw_protect,
  input wire logic        sw_loader,
  input wire logic        nv_flag_in,
  input wire logic [10:0] led,
  input wire logic        run_loader,
  input wire logic        prog_erase,
  input wire logic        nv_wr_en,
  input wire logic        nv_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        seen_q, seen_d, img_q, img_d, rd_st, rd_sr;
  logic [15:0] lit_q, lit_d;
  // ************************************************************
  // Shadow of the stored flag and length of the lit phase
  // ************************************************************
  assign rd_st = psel && penable && pready && !pwrite && paddr == boot_cfg_pkg::OFF_STATUS;
  assign rd_sr = psel && penable && pready && !pwrite && run_loader &&
                 (paddr == boot_cfg_pkg::OFF_OPER || paddr == boot_cfg_pkg::OFF_QUES);
  always_comb begin
    seen_d = 1'b1;
    img_d  = seen_q ? img_q : nv_flag_in;
    if (nv_wr_en) begin
      img_d = nv_wr_data;
    end
    lit_d  = (led == '1) ? lit_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
      img_q  <= 1'b0;
      lit_q  <= 16'h0;
    end else begin
      seen_q <= seen_d;
      img_q  <= img_d;
      lit_q  <= lit_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_addr_field: assert property (rd_st |-> prdata[7:0] == {sw_row, sw_col})
    else $error("status address field wrong");
  chk_illegal_addr: assert property (
    rd_st |-> prdata[8] == (sw_row == 3'h0 && sw_col == 5'h1F))
    else $error("illegal address flag wrong");
  chk_erase_guard: assert property (prog_erase |-> !sw_protect && run_loader)
    else $error("erase while secured or outside loader");
  chk_loader_switch: assert property ($fell(led[0]) && sw_loader |-> run_loader)
    else $error("loader switch ignored at power-up");
  chk_test_span: assert property (
    $fell(led[0]) |-> lit_q == 16'(SELFTEST_CYCLES) && led == '0)
    else $error("indicator test phase length wrong");
  chk_image_fixed: assert property ($rose(run_loader) |-> $fell(led[0]))
    else $error("image changed outside power-up");
  chk_loader_rewrite: assert property (
    $rose(run_loader) && img_q |-> ##[1:3] (nv_wr_en && !nv_wr_data))
    else $error("loader start did not store instrument");
  chk_nv_change: assert property (nv_wr_en |-> nv_wr_data != img_q)
    else $error("stored value rewritten unchanged");
  chk_sr_quiet: assert property (rd_sr |-> prdata[31:16] == 16'h0)
    else $error("status event bits set in loader");
endmodule // boot_config_properties
bind boot_config boot_config_properties #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) chk_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .sw_row, .sw_col,
  .sw_protect, .sw_loader, .nv_flag_in, .led, .run_loader, .prog_erase, .nv_wr_en,
  .nv_wr_data);
`default_nettype wire

// ===== testbench/host_apb_model.sv
// Host controller model issuing register accesses over APB
`default_nettype none
module host_apb_model (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // Leading edge keeps back-to-back calls from driving psel twice in one step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // host_apb_model
`default_nettype wire

// ===== testbench/boot_config_tb.sv
// Self-checking bench for the boot-source and configuration block
`default_nettype none
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); \
  end \
end
module boot_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        sw_protect, sw_loader, sw_aux1, sw_aux2, selftest_fault, nv_flag_in;
  logic        run_loader, prog_erase, nv_wr_en, nv_wr_data;
  logic [2:0]  sw_row;
  logic [4:0]  sw_col;
  logic [7:0]  paddr;
  logic [10:0] led;
  logic [15:0] oper_cond, ques_cond;
  logic [31:0] pwdata, prdata, rd, seed;
  int          fails, checks_done, cycles, m_stored, m_nv, m_run, m_rej, m_err;
  int          erase_exp, erase_seen, wr_exp, wr_seen;
  int          oq[$];
  boot_config #(.SELFTEST_CYCLES(ST)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sw_row, .sw_col, .sw_protect, .sw_loader, .sw_aux1,
    .sw_aux2, .selftest_fault, .nv_flag_in, .oper_cond, .ques_cond, .led, .run_loader,
    .prog_erase, .nv_wr_en, .nv_wr_data);
  host_apb_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (prog_erase === 1'b1) erase_seen++;
    if (nv_wr_en === 1'b1) begin
      wr_seen++;
      `CHK("nv data", m_nv, nv_wr_data)
    end
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Repeated values skip the write, as the stored copy wears out
  task automatic store(input int v);
    m_stored = v;
    if (v != m_nv) begin
      m_nv = v;
      wr_exp++;
    end
  endtask
  function automatic logic [31:0] st_exp();
    return {16'h0, m_rej[0], 2'b00, m_stored[0], m_run[0], sw_loader, sw_protect,
            sw_row == boot_cfg_pkg::ILLEGAL_ROW && sw_col == boot_cfg_pkg::ILLEGAL_COL,
            sw_row, sw_col};
  endfunction
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string n);
    host.xfer(1'b0, a, 32'h0, rd, err);
    `CHK(n, e, rd)
  endtask
  // Commands are dropped while the sequencer is busy, so wait for both busy bits to clear
  task automatic idle();
    repeat (400) begin
      host.xfer(1'b0, boot_cfg_pkg::OFF_STATUS, 32'h0, rd, err);
      `CHK("status", st_exp(), rd & 32'hFFFF9FFF)
      m_rej = 0;
      if (rd[14:13] === 2'b00) break;
    end
  endtask
  task automatic power_up(input logic ld_sw, input logic flag, input logic [7:0] adr);
    int n;
    n = 0;
    presetn          <= 1'b0;
    sw_loader        <= ld_sw;
    nv_flag_in       <= flag;
    {sw_row, sw_col} <= adr;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (100) begin
      @(posedge pclk);
      if (led === '1) n++;
      else if (n > 0) break;
    end
    m_nv = flag;
    m_stored = flag;
    m_run = ld_sw | flag;
    m_rej = 0;
    m_err = 0;
    oq.delete();
    `CHK("test span", ST, n)
    `CHK("led off", 0, led)
    `CHK("image", m_run, run_loader)
    if (m_run) store(0);
    idle();
    `CHK("nv writes", wr_exp, wr_seen)
  endtask
  task automatic cmd(input logic [3:0] c);
    {sw_aux1, sw_aux2} <= 2'(xs());
    {oper_cond, ques_cond} <= xs();
    selftest_fault <= 1'(xs());
    host.xfer(1'b1, boot_cfg_pkg::OFF_CMD, {28'h0, c}, rd, err);
    if (c == boot_cfg_pkg::CMD_BOOT_INST || c == boot_cfg_pkg::CMD_RESET) store(0);
    if (c == boot_cfg_pkg::CMD_BOOT_LOADER) store(1);
    if (c == boot_cfg_pkg::CMD_BOOT_QUERY) oq.push_back(32'hC0000000 | m_stored);
    if (c == boot_cfg_pkg::CMD_SELFTEST) oq.push_back(32'h80000000 | selftest_fault);
    if (c == boot_cfg_pkg::CMD_APP && m_run) m_rej = 1;
    if (c == boot_cfg_pkg::CMD_ERASE || c == boot_cfg_pkg::CMD_LOAD_OK) begin
      if (!m_run) m_rej = 1;
      else if (sw_protect) m_err = (c == boot_cfg_pkg::CMD_ERASE) ?
        boot_cfg_pkg::ERR_MEDIA_PROTECTED : boot_cfg_pkg::ERR_PROG_PROTECTED;
      else if (c == boot_cfg_pkg::CMD_ERASE) erase_exp++;
      else store(0);
    end
    idle();
    `CHK("image", m_run, run_loader)
    `CHK("led", 0, led)
    `CHK("nv writes", wr_exp, wr_seen)
    `CHK("erase pulses", erase_exp, erase_seen)
  endtask
  task automatic run_set(input logic prot);
    logic [15:0] en;
    logic [7:0]  a;
    sw_protect <= prot;
    for (int c = 0; c < 10; c++) begin
      cmd(4'(c));
      chk_rd(boot_cfg_pkg::OFF_OUTQ, oq.size() ? oq.pop_front() : 0, "outq");
      chk_rd(boot_cfg_pkg::OFF_ERR, m_err, "error");
      m_err = 0;
    end
    for (int i = 0; i < 2; i++) begin
      a  = i ? boot_cfg_pkg::OFF_QUES : boot_cfg_pkg::OFF_OPER;
      en = 16'(xs());
      host.xfer(1'b1, a, {16'h0, en}, rd, err);
      chk_rd(a, {m_run ? 16'h0 : ((i ? ques_cond : oper_cond) & en), en}, "sr");
    end
    host.xfer(1'b0, 8'h18, 32'h0, rd, err);
    `CHK("unmapped", 33'h100000000, {err, rd})
  endtask
  initial begin
    seed = 32'h28AE;
    presetn = 1'b0;
    sw_protect = 1'b1;
    sw_loader = 1'b0;
    sw_aux1 = 1'b0;
    sw_aux2 = 1'b0;
    selftest_fault = 1'b0;
    nv_flag_in = 1'b0;
    {sw_row, sw_col} = 8'h16;
    {oper_cond, ques_cond} = 32'h0;
    @(posedge pclk);
    power_up(1'b0, 1'b1, 8'(xs()));
    run_set(1'b1);
    run_set(1'b0);
    power_up(1'b1, 1'b0, 8'h1F);
    run_set(1'b0);
    power_up(1'b0, 1'b0, 8'(xs()));
    run_set(1'b1);
    run_set(1'b0);
    give_verdict();
  end
endmodule // boot_config_tb
`undef CHK
`default_nettype wire
